//--- hdl/slot_xfer_pkg.sv
package slot_xfer_pkg;
	// Register offsets on the four-bit host port
	localparam logic [3:0] OFF_OP_CONTROL = 4'h0;
	localparam logic [3:0] OFF_ADDR_SELECT = 4'h1;
	localparam logic [3:0] OFF_DATA_PORT = 4'h2;
	localparam logic [3:0] OFF_XA_DATA = 4'h3;
	localparam logic [3:0] OFF_XB_DATA = 4'h4;
	localparam logic [3:0] OFF_XA_RX = 4'h5;
	localparam logic [3:0] OFF_XB_RX = 4'h6;
	localparam logic [3:0] OFF_XA_TX = 4'h7;
	localparam logic [3:0] OFF_XB_TX = 4'h8;
	localparam logic [3:0] OFF_XFER_CTL = 4'h9;
	// Field positions
	localparam int DIR_BIT = 7;
	localparam int IFACE_BIT = 7;
	localparam int EN_A_BIT = 6;
	localparam int EN_B_BIT = 7;
	localparam int TYPE_A_LSB = 0;
	localparam int TYPE_B_LSB = 3;
	localparam logic [7:0] XFER_CTL_RST = 8'h00;
	localparam logic [7:0] REG_RST = 8'h00;
	// Memory operation codes
	localparam logic [7:0] OP_CM_CODE_RD = 8'hF0;
	localparam logic [6:0] OP_CM_DATA = 7'h48;
	localparam logic [3:0] OP_CM_ALL_WR = 4'h7;
	localparam logic [2:0] OP_DM_LOW = 3'h0;
	localparam logic [7:0] FULL_MASK = 8'hFF;
	// Trunk and subscriber modes
	localparam logic [1:0] MODE_0 = 2'h0;
	localparam logic [1:0] MODE_1 = 2'h1;
	localparam logic [1:0] MODE_2 = 2'h2;
	localparam logic [1:0] MODE_3 = 2'h3;
	localparam logic [2:0] TYPE_64K = 3'h1;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_FINISH = 3'b100
	} op_state_t;

	// Channel type code to the trunk bits it carries
	function automatic logic [7:0] type_mask(input logic [2:0] t);
		case (t)
			3'h1: type_mask = 8'hFF;
			3'h2: type_mask = 8'h0F;
			3'h3: type_mask = 8'hF0;
			3'h4: type_mask = 8'h03;
			3'h5: type_mask = 8'h0C;
			3'h6: type_mask = 8'h30;
			3'h7: type_mask = 8'hC0;
			default: type_mask = 8'h00;
		endcase
	endfunction : type_mask
endpackage : slot_xfer_pkg

//--- hdl/slot_mem_if.sv
`timescale 1ns/1ps
interface slot_mem_if #(parameter int W = 8);
	logic we;
	logic [7:0] addr;
	logic [W-1:0] wdata;
	logic [W-1:0] rdata;
	modport ram (input we, input addr, input wdata, output rdata);
	modport user (output we, output addr, output wdata, input rdata);
endinterface : slot_mem_if

//--- hdl/slot_ram.sv
`timescale 1ns/1ps
module slot_ram #(
	parameter int W = 8
) (
	input wire logic clk_sys,
	slot_mem_if.ram port
);
	logic [W-1:0] mem [256];

	// Contents are undefined after reset, as on the real memory
	always_ff @(posedge clk_sys) begin
		if (port.we) begin
			mem[port.addr] <= port.wdata;
		end
		port.rdata <= mem[port.addr];
	end
endmodule : slot_ram

//--- hdl/slot_xfer_top.sv
`timescale 1ns/1ps
// How it works
// - Code read op puts the slot's four-bit code in data port bits 3..0.
// - Address bit 7 picks upstream or downstream memory block.
// - Control memory addresses are subscriber slots, data memory trunk slots.
// - Data memory address decoding follows the trunk mode.
// - Control memory address decoding follows the subscriber mode.
// - Data port holds the byte written to or read from memory.
// - Channel A data register buffers its slot byte, bit 7 first.
// - Channel B data register buffers its slot byte, bit 7 first.
// - Channel A receive select: 0 trunk, 1 subscriber as source.
// - Channel B receive select: 0 trunk, 1 subscriber as source.
// - Channel A transmit select: 0 trunk, 1 subscriber as sink.
// - Channel B transmit select: 0 trunk, 1 subscriber as sink.
// - Channel slot fields use the same seven-bit encoding as memory addresses.
// - Enable bits switch each channel on at 1, off at 0.
// - Channel type fields set trunk subslot bandwidth and bit position.
// - Type codes map to bit groups; code 000 carries nothing.
// - Busy flag also pulses for one cycle after each channel transfer.
module slot_xfer_top (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [3:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic [1:0] pcm_mode,
	input wire logic [1:0] cfi_mode,
	output logic memory_access_busy,
	input wire logic trunk_slot_valid,
	input wire logic [6:0] trunk_slot_addr,
	input wire logic [7:0] trunk_rx_byte,
	output logic [7:0] trunk_tx_byte,
	output logic [7:0] trunk_tx_mask,
	input wire logic sub_slot_valid,
	input wire logic [6:0] sub_slot_addr,
	input wire logic [7:0] sub_rx_byte,
	output logic [7:0] sub_tx_byte,
	output logic sub_tx_en
);
	slot_mem_if #(.W(8)) cm_data_if ();
	slot_mem_if #(.W(4)) cm_code_if ();
	slot_mem_if #(.W(8)) dm_if ();

	slot_ram #(.W(8)) u_cm_data (.clk_sys(clk_sys), .port(cm_data_if.ram));
	slot_ram #(.W(4)) u_cm_code (.clk_sys(clk_sys), .port(cm_code_if.ram));
	slot_ram #(.W(8)) u_dm (.clk_sys(clk_sys), .port(dm_if.ram));

	logic [7:0] op_q;
	logic [7:0] addr_q;
	logic [7:0] mdr_q;
	logic [7:0] xfer_data_q [2];
	logic [7:0] rx_slot_q [2];
	logic [7:0] tx_slot_q [2];
	logic [7:0] xfer_ctl_q;
	logic xfer_busy_q;
	slot_xfer_pkg::op_state_t state_q;
	logic launch;
	logic op_write;
	logic is_cm_code_rd;
	logic is_cm_all_wr;
	logic is_cm_data;
	logic is_dm;
	logic [6:0] cm_lin;
	logic [6:0] dm_lin;
	logic [7:0] dm_merge;
	logic [1:0] chan_en;
	logic [2:0] chan_type [2];
	logic [1:0] rx_hit_trunk;
	logic [1:0] rx_hit_sub;
	logic [1:0] tx_hit_trunk;
	logic [1:0] tx_hit_sub;

	// Decode of the stored operation byte
	assign op_write = ~op_q[7];
	assign is_cm_code_rd = (op_q == slot_xfer_pkg::OP_CM_CODE_RD);
	assign is_cm_all_wr = (op_q[7:4] == slot_xfer_pkg::OP_CM_ALL_WR);
	assign is_cm_data = (op_q[6:0] == slot_xfer_pkg::OP_CM_DATA);
	assign is_dm = ~op_q[6] && (op_q[2:0] == slot_xfer_pkg::OP_DM_LOW) && (op_q[5:3] != 3'h0);

	// Subscriber slot order: logical port above slot bits
	always_comb begin
		case (cfi_mode)
			slot_xfer_pkg::MODE_0: cm_lin = {addr_q[2:1], addr_q[6:3], addr_q[0]};
			slot_xfer_pkg::MODE_1: cm_lin = {addr_q[1], addr_q[6:3], addr_q[2], addr_q[0]};
			slot_xfer_pkg::MODE_2: cm_lin = addr_q[6:0];
			default: cm_lin = {addr_q[3:1], addr_q[6:4], addr_q[0]};
		endcase
	end

	// Trunk slot order; modes 1 and 3 share one layout
	always_comb begin
		case (pcm_mode)
			slot_xfer_pkg::MODE_0: dm_lin = {addr_q[2:1], addr_q[6:3], addr_q[0]};
			slot_xfer_pkg::MODE_2: dm_lin = addr_q[6:0];
			default: dm_lin = {addr_q[2], addr_q[6:3], addr_q[1:0]};
		endcase
	end

	// Subchannel write keeps the untouched bits of the stored byte
	assign dm_merge = (dm_if.rdata & ~slot_xfer_pkg::type_mask(op_q[5:3]))
		| (mdr_q & slot_xfer_pkg::type_mask(op_q[5:3]));

	// Memory ports; control memory on subscriber slots, data memory on trunk slots
	assign cm_data_if.addr = {addr_q[slot_xfer_pkg::DIR_BIT], cm_lin};
	assign cm_code_if.addr = {addr_q[slot_xfer_pkg::DIR_BIT], cm_lin};
	assign dm_if.addr = {addr_q[slot_xfer_pkg::DIR_BIT], dm_lin};
	assign cm_data_if.wdata = mdr_q;
	assign cm_code_if.wdata = op_q[3:0];
	assign dm_if.wdata = dm_merge;
	assign cm_data_if.we = (state_q == slot_xfer_pkg::ST_FINISH) && op_write
		&& (is_cm_data || is_cm_all_wr);
	assign cm_code_if.we = (state_q == slot_xfer_pkg::ST_FINISH) && is_cm_all_wr;
	assign dm_if.we = (state_q == slot_xfer_pkg::ST_FINISH) && op_write && is_dm;

	// Writing the op register starts an access; ignored while busy
	assign launch = bus_wr && (bus_addr == slot_xfer_pkg::OFF_OP_CONTROL)
		&& !memory_access_busy;
	assign memory_access_busy = (state_q != slot_xfer_pkg::ST_IDLE) || xfer_busy_q;

	// Access sequencer: read cycle, then write-back or capture
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= slot_xfer_pkg::ST_IDLE;
		end else begin
			case (state_q)
				slot_xfer_pkg::ST_IDLE: if (launch) state_q <= slot_xfer_pkg::ST_READ;
				slot_xfer_pkg::ST_READ: state_q <= slot_xfer_pkg::ST_FINISH;
				slot_xfer_pkg::ST_FINISH: state_q <= slot_xfer_pkg::ST_IDLE;
				default: state_q <= slot_xfer_pkg::ST_IDLE;
			endcase
		end
	end

	// Host registers of the memory path
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			op_q <= slot_xfer_pkg::REG_RST;
			addr_q <= slot_xfer_pkg::REG_RST;
			mdr_q <= slot_xfer_pkg::REG_RST;
		end else begin
			if (launch) begin
				op_q <= bus_wdata;
			end
			if (bus_wr && bus_addr == slot_xfer_pkg::OFF_ADDR_SELECT) begin
				addr_q <= bus_wdata;
			end
			if (state_q == slot_xfer_pkg::ST_FINISH && !op_write) begin
				if (is_cm_code_rd) begin
					mdr_q <= {4'h0, cm_code_if.rdata};
				end else if (is_cm_data) begin
					mdr_q <= cm_data_if.rdata;
				end else if (is_dm) begin
					mdr_q <= dm_if.rdata;
				end
			end else if (bus_wr && bus_addr == slot_xfer_pkg::OFF_DATA_PORT) begin
				mdr_q <= bus_wdata;
			end
		end
	end

	// Transfer control fields
	assign chan_en[0] = xfer_ctl_q[slot_xfer_pkg::EN_A_BIT];
	assign chan_en[1] = xfer_ctl_q[slot_xfer_pkg::EN_B_BIT];
	assign chan_type[0] = xfer_ctl_q[slot_xfer_pkg::TYPE_A_LSB +: 3];
	assign chan_type[1] = xfer_ctl_q[slot_xfer_pkg::TYPE_B_LSB +: 3];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			xfer_ctl_q <= slot_xfer_pkg::XFER_CTL_RST;
		end else if (bus_wr && bus_addr == slot_xfer_pkg::OFF_XFER_CTL) begin
			xfer_ctl_q <= bus_wdata;
		end
	end

	// Per-channel slot matching, compared in host address encoding
	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_chan
			logic rx_sub;
			logic tx_sub;
			assign rx_sub = rx_slot_q[c][slot_xfer_pkg::IFACE_BIT];
			assign tx_sub = tx_slot_q[c][slot_xfer_pkg::IFACE_BIT];
			assign rx_hit_trunk[c] = chan_en[c] && !rx_sub && trunk_slot_valid
				&& trunk_slot_addr == rx_slot_q[c][6:0];
			assign rx_hit_sub[c] = chan_en[c] && rx_sub && sub_slot_valid
				&& sub_slot_addr == rx_slot_q[c][6:0];
			assign tx_hit_trunk[c] = chan_en[c] && !tx_sub && trunk_slot_valid
				&& trunk_slot_addr == tx_slot_q[c][6:0];
			assign tx_hit_sub[c] = chan_en[c] && tx_sub && sub_slot_valid
				&& sub_slot_addr == tx_slot_q[c][6:0];

			// Serial capture wins over a host write in the same cycle
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					xfer_data_q[c] <= slot_xfer_pkg::REG_RST;
					rx_slot_q[c] <= slot_xfer_pkg::REG_RST;
					tx_slot_q[c] <= slot_xfer_pkg::REG_RST;
				end else begin
					if (rx_hit_trunk[c]) begin
						xfer_data_q[c] <= (xfer_data_q[c] & ~slot_xfer_pkg::type_mask(chan_type[c]))
							| (trunk_rx_byte & slot_xfer_pkg::type_mask(chan_type[c]));
					end else if (rx_hit_sub[c]) begin
						xfer_data_q[c] <= sub_rx_byte;
					end else if (bus_wr && bus_addr == slot_xfer_pkg::OFF_XA_DATA + 4'(c)) begin
						xfer_data_q[c] <= bus_wdata;
					end
					if (bus_wr && bus_addr == slot_xfer_pkg::OFF_XA_RX + 4'(c)) begin
						rx_slot_q[c] <= bus_wdata;
					end
					if (bus_wr && bus_addr == slot_xfer_pkg::OFF_XA_TX + 4'(c)) begin
						tx_slot_q[c] <= bus_wdata;
					end
				end
			end
		end
	endgenerate

	// Highway outputs; channel A takes precedence on a shared slot
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			trunk_tx_byte <= 8'h00;
			trunk_tx_mask <= 8'h00;
			sub_tx_byte <= 8'h00;
			sub_tx_en <= 1'b0;
		end else begin
			trunk_tx_mask <= 8'h00;
			sub_tx_en <= 1'b0;
			if (tx_hit_trunk[0]) begin
				trunk_tx_byte <= xfer_data_q[0];
				trunk_tx_mask <= slot_xfer_pkg::type_mask(chan_type[0]);
			end else if (tx_hit_trunk[1]) begin
				trunk_tx_byte <= xfer_data_q[1];
				trunk_tx_mask <= slot_xfer_pkg::type_mask(chan_type[1]);
			end
			if (tx_hit_sub[0]) begin
				sub_tx_byte <= xfer_data_q[0];
				sub_tx_en <= 1'b1;
			end else if (tx_hit_sub[1]) begin
				sub_tx_byte <= xfer_data_q[1];
				sub_tx_en <= 1'b1;
			end
		end
	end

	// Busy pulses for one cycle after each transfer touches a register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			xfer_busy_q <= 1'b0;
		end else begin
			xfer_busy_q <= |{rx_hit_trunk, rx_hit_sub, tx_hit_trunk, tx_hit_sub};
		end
	end

	// Registered read data; unmapped offsets answer zero
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= 8'h00;
		end else if (bus_rd) begin
			case (bus_addr)
				slot_xfer_pkg::OFF_OP_CONTROL: bus_rdata <= op_q;
				slot_xfer_pkg::OFF_ADDR_SELECT: bus_rdata <= addr_q;
				slot_xfer_pkg::OFF_DATA_PORT: bus_rdata <= mdr_q;
				slot_xfer_pkg::OFF_XA_DATA: bus_rdata <= xfer_data_q[0];
				slot_xfer_pkg::OFF_XB_DATA: bus_rdata <= xfer_data_q[1];
				slot_xfer_pkg::OFF_XA_RX: bus_rdata <= rx_slot_q[0];
				slot_xfer_pkg::OFF_XB_RX: bus_rdata <= rx_slot_q[1];
				slot_xfer_pkg::OFF_XA_TX: bus_rdata <= tx_slot_q[0];
				slot_xfer_pkg::OFF_XB_TX: bus_rdata <= tx_slot_q[1];
				slot_xfer_pkg::OFF_XFER_CTL: bus_rdata <= xfer_ctl_q;
				default: bus_rdata <= 8'h00;
			endcase
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_code_readback: assert property ((state_q == slot_xfer_pkg::ST_FINISH) && is_cm_code_rd
		|=> mdr_q[7:4] == 4'h0 && mdr_q[3:0] == $past(cm_code_if.rdata))
		else $error("code readback wrong");
	a_dir_bit: assert property ((state_q == slot_xfer_pkg::ST_READ)
		|-> dm_if.addr[7] == addr_q[7] && cm_data_if.addr[7] == addr_q[7])
		else $error("direction bit lost");
	a_dm_mode0: assert property ((pcm_mode == 2'h0)
		|-> dm_if.addr[6:0] == {addr_q[2:1], addr_q[6:3], addr_q[0]})
		else $error("trunk decode wrong");
	a_cm_mode3: assert property ((cfi_mode == 2'h3)
		|-> cm_code_if.addr[6:0] == {addr_q[3:1], addr_q[6:4], addr_q[0]})
		else $error("subscriber decode wrong");
	a_op_sequence: assert property (launch |=> state_q == slot_xfer_pkg::ST_READ
		##1 state_q == slot_xfer_pkg::ST_FINISH ##1 state_q == slot_xfer_pkg::ST_IDLE)
		else $error("access sequence broken");
	a_busy_on_xfer: assert property ((|tx_hit_sub) |=> memory_access_busy && sub_tx_en)
		else $error("busy not raised on transfer");
	a_full_capture: assert property (rx_hit_trunk[0] && chan_type[0] == 3'h1
		|=> xfer_data_q[0] == $past(trunk_rx_byte))
		else $error("trunk capture wrong");
	a_sub_capture: assert property (rx_hit_sub[1] |=> xfer_data_q[1] == $past(sub_rx_byte))
		else $error("subscriber capture wrong");
	a_disabled_quiet: assert property (chan_en == 2'b00
		|=> !sub_tx_en && trunk_tx_mask == 8'h00)
		else $error("disabled channel drove slot");
	a_half_mask: assert property (tx_hit_trunk[0] && chan_type[0] == 3'h3
		|=> trunk_tx_mask == 8'hF0)
		else $error("subslot mask wrong");

	c_code_read: cover property (launch && bus_wdata == 8'hF0 ##3 state_q == slot_xfer_pkg::ST_IDLE);
	c_dm_write: cover property ((state_q == slot_xfer_pkg::ST_FINISH) && dm_if.we);
	c_loop_both: cover property (rx_hit_trunk[0] ##[1:20] tx_hit_sub[0]);
endmodule : slot_xfer_top

//--- sim/slot_highway_model.sv
`timescale 1ns/1ps
// Far side of both serial highways, one parallel slot strobe per call
module slot_highway_model (
	input wire logic clk_sys,
	output logic trunk_slot_valid,
	output logic [6:0] trunk_slot_addr,
	output logic [7:0] trunk_rx_byte,
	output logic sub_slot_valid,
	output logic [6:0] sub_slot_addr,
	output logic [7:0] sub_rx_byte
);
	// Idle highways at time zero
	initial begin
		trunk_slot_valid = 1'h0;
		sub_slot_valid = 1'h0;
		trunk_slot_addr = 7'h00;
		sub_slot_addr = 7'h00;
		trunk_rx_byte = 8'h00;
		sub_rx_byte = 8'h00;
	end

	// One slot for one cycle; lines inverted after so stale bytes never match
	task automatic slot(input logic sub, input logic [6:0] a, input logic [7:0] b);
		@(posedge clk_sys);
		#1;
		trunk_slot_addr = a;
		sub_slot_addr = a;
		trunk_rx_byte = b;
		sub_rx_byte = b;
		trunk_slot_valid = ~sub;
		sub_slot_valid = sub;
		@(posedge clk_sys);
		#1;
		trunk_slot_valid = 1'h0;
		sub_slot_valid = 1'h0;
		trunk_slot_addr = ~a;
		sub_slot_addr = ~a;
		trunk_rx_byte = ~b;
		sub_rx_byte = ~b;
	endtask : slot
endmodule : slot_highway_model

//--- sim/test_slot_memory_access_sync_transfer.sv
`timescale 1ns/1ps
module test_slot_memory_access_sync_transfer;
	logic clk_sys = 1'h0;
	logic rst_n = 1'h0;
	logic [3:0] bus_addr = 4'h0;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_wr = 1'h0;
	logic bus_rd = 1'h0;
	logic [7:0] bus_rdata, trunk_tx_byte, trunk_tx_mask, sub_tx_byte, trunk_rx_byte, sub_rx_byte;
	logic [1:0] pcm_mode = 2'h0;
	logic [1:0] cfi_mode = 2'h0;
	logic memory_access_busy, trunk_slot_valid, sub_slot_valid, sub_tx_en;
	logic [6:0] trunk_slot_addr, sub_slot_addr;
	int n_errors = 0;
	int checks = 0;
	int seed;

	slot_xfer_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.pcm_mode(pcm_mode), .cfi_mode(cfi_mode), .memory_access_busy(memory_access_busy),
		.trunk_slot_valid(trunk_slot_valid), .trunk_slot_addr(trunk_slot_addr),
		.trunk_rx_byte(trunk_rx_byte), .trunk_tx_byte(trunk_tx_byte),
		.trunk_tx_mask(trunk_tx_mask), .sub_slot_valid(sub_slot_valid),
		.sub_slot_addr(sub_slot_addr), .sub_rx_byte(sub_rx_byte), .sub_tx_byte(sub_tx_byte),
		.sub_tx_en(sub_tx_en));
	slot_highway_model hw (.clk_sys(clk_sys), .trunk_slot_valid(trunk_slot_valid),
		.trunk_slot_addr(trunk_slot_addr), .trunk_rx_byte(trunk_rx_byte),
		.sub_slot_valid(sub_slot_valid), .sub_slot_addr(sub_slot_addr),
		.sub_rx_byte(sub_rx_byte));

	// 25 MHz system clock
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic final_report;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	// Generous bound, the whole run needs under a thousand cycles
	initial begin
		#(40 * 20000);
		n_errors++;
		final_report();
	end

	// Single-cycle strobes, inputs move 1 ns after the edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'h1;
		@(posedge clk_sys);
		#1;
		bus_wr = 1'h0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		#1;
		bus_addr = a;
		bus_rd = 1'h1;
		@(posedge clk_sys);
		#1;
		bus_rd = 1'h0;
		d = bus_rdata;
	endtask : rd

	// Busy must drop within a bounded wait before any new access
	task automatic wait_idle;
		int n;
		n = 0;
		while (memory_access_busy !== 1'h0 && n < 50) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n >= 50) check("busy_wait", 8'h01, 8'h00);
	endtask : wait_idle

	task automatic mem_op(input logic [7:0] a, input logic [7:0] d, input logic [7:0] op);
		wait_idle();
		wr(slot_xfer_pkg::OFF_ADDR_SELECT, a);
		wr(slot_xfer_pkg::OFF_DATA_PORT, d);
		wr(slot_xfer_pkg::OFF_OP_CONTROL, op);
		wait_idle();
	endtask : mem_op

	// Bench's own type table: bit group carried by each channel type code
	function automatic logic [7:0] fmask(input int t);
		if (t == 0) return 8'h00;
		if (t == 1) return 8'hFF;
		if (t < 4) return (t == 2) ? 8'h0F : 8'hF0;
		return 8'h03 << (2 * (t - 4));
	endfunction : fmask

	initial begin
		logic [7:0] v, x, a, d, d2, m, xa, xb;
		logic [6:0] ra, ta;
		logic [3:0] c;
		int t;
		seed = $urandom(32'h5497);
		repeat (12) @(posedge clk_sys);
		#1;
		rst_n = 1'h1;
		// Reset values, read-back, unmapped place
		for (int i = 1; i <= 10; i++) begin
			rd(4'(i), v);
			check("reset", v, 8'h00);
		end
		for (int i = 1; i <= 9; i++) begin
			x = 8'($urandom);
			wr(4'(i), x);
			rd(4'(i), v);
			check("readback", v, x);
		end
		wr(4'hA, 8'h5A);
		rd(4'hA, v);
		check("unmapped", v, 8'h00);
		wr(slot_xfer_pkg::OFF_XFER_CTL, 8'h00);
		$display("test registers done");
		// Memory accesses under eight mode pairs, covering every mode of each
		for (int i = 0; i < 8; i++) begin
			pcm_mode = 2'(i);
			cfi_mode = 2'(i >> 1);
			a = 8'($urandom);
			d = 8'($urandom);
			d2 = 8'($urandom);
			t = 2 + ($urandom % 6);
			m = fmask(t);
			mem_op(a, d, 8'h08);
			mem_op(a ^ 8'h80, ~d, 8'h08);
			mem_op(a, d2, {2'h0, 3'(t), 3'h0});
			mem_op(a, 8'h00, {2'h2, 3'(t), 3'h0});
			rd(slot_xfer_pkg::OFF_DATA_PORT, v);
			check("dm_merge", v, (d & ~m) | (d2 & m));
			mem_op(a ^ 8'h80, 8'h00, 8'h88);
			rd(slot_xfer_pkg::OFF_DATA_PORT, v);
			check("dm_dir", v, ~d);
			c = 4'($urandom);
			mem_op(a, d2, {4'h7, c});
			mem_op(a, 8'h00, 8'hF0);
			rd(slot_xfer_pkg::OFF_DATA_PORT, v);
			check("cm_code", v, {4'h0, c});
			mem_op(a, 8'h00, 8'hC8);
			rd(slot_xfer_pkg::OFF_DATA_PORT, v);
			check("cm_data", v, d2);
		end
		$display("test memory done");
		// Channel A trunk to subscriber, channel B subscriber in
		ra = 7'($urandom);
		ta = 7'($urandom);
		xa = 8'($urandom);
		xb = 8'($urandom);
		wr(slot_xfer_pkg::OFF_XA_RX, {1'h0, ra});
		wr(slot_xfer_pkg::OFF_XA_TX, {1'h1, ta});
		wr(slot_xfer_pkg::OFF_XB_RX, {1'h1, ta ^ 7'h01});
		wr(slot_xfer_pkg::OFF_XB_TX, {1'h0, ra ^ 7'h01});
		wr(slot_xfer_pkg::OFF_XFER_CTL, 8'hC9);
		hw.slot(1'h0, ra, xa);
		check("busy_pulse", {7'h00, memory_access_busy}, 8'h01);
		rd(slot_xfer_pkg::OFF_XA_DATA, v);
		check("a_capture", v, xa);
		hw.slot(1'h1, ta, ~xa);
		check("a_sub_en", {7'h00, sub_tx_en}, 8'h01);
		check("a_sub_byte", sub_tx_byte, xa);
		hw.slot(1'h1, ta ^ 7'h01, xb);
		rd(slot_xfer_pkg::OFF_XB_DATA, v);
		check("b_capture", v, xb);
		// Channel B trunk output through every type code
		for (t = 0; t < 8; t++) begin
			wr(slot_xfer_pkg::OFF_XFER_CTL, {2'h2, 3'(t), 3'h1});
			hw.slot(1'h0, ra ^ 7'h01, 8'($urandom));
			check("b_mask", trunk_tx_mask, fmask(t));
			check("b_byte", trunk_tx_byte & fmask(t), xb & fmask(t));
		end
		// Channel A trunk capture merges only the type's bits
		for (t = 2; t < 8; t++) begin
			x = 8'($urandom);
			wr(slot_xfer_pkg::OFF_XFER_CTL, {2'h1, 3'h1, 3'(t)});
			hw.slot(1'h0, ra, x);
			xa = (xa & ~fmask(t)) | (x & fmask(t));
			rd(slot_xfer_pkg::OFF_XA_DATA, v);
			check("a_merge", v, xa);
		end
		// Both channels off: no capture, no drive, no busy
		wr(slot_xfer_pkg::OFF_XFER_CTL, 8'h09);
		hw.slot(1'h0, ra, ~xa);
		check("off_busy", {7'h00, memory_access_busy}, 8'h00);
		hw.slot(1'h0, ra ^ 7'h01, xa);
		check("off_mask", trunk_tx_mask, 8'h00);
		rd(slot_xfer_pkg::OFF_XA_DATA, v);
		check("off_data", v, xa);
		$display("test transfers done");
		final_report();
	end
endmodule : test_slot_memory_access_sync_transfer
